// file: logic/scm_top.v
// Serial client datapath with select handling and APB registers
//
// Summary of operation
// R1: Direction clear: output pin always driven.
// R2: Inactive and output: drive pin latch value.
// R3: Direction set: drive only when required and selected.
// R4: Not required: send oldest queued byte, keep it.
// R5: Required: send oldest queued byte, remove it.
// R6: Required, queue empty: echo last byte, underflow.
// R7: Not required, queue empty: echo, no underflow.
// R8: Receive required and room: store each byte.
// R9: Receive required and full: discard, set overflow.
// R10: Receive not required: keep last byte only.
// R11: Unselected: ignore clock, no transfer; pin at latch level if direction clear, else released.
// R12: Select lost mid transfer sets fault flag.
// R13: Polarity set means select is active low.
// R14: Force active overrides the real select input.
// R15: Select end returns receiver to idle.
// R16: Host keeps select inactive until ready.
// R17: Clock polarity and edge match the host.
// R18: Separate clock pins: clock out follows in.
// R19: Select edges set start and end flags.
// R20: Eight bits per byte, MSB first default.
`timescale 1ns/100ps
`include "scm_consts.vh"
module scm_top (
   // APB clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // Serial pins from the host
   input wire sck_in,
   input wire ss_in,
   input wire sdi_in,
   // Serial data out pin
   output reg sdo_out,
   output reg sdo_oe_n,
   // Chained clock out pin
   output reg sck_out,
   output reg sck_oe_n
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   reg [`SCM_CTRL_W-1:0] ctrl; // Control bits
   reg [`SCM_FLAG_W-1:0] flags; // Sticky event flags
   reg [7:0] tcnt; // Expected bytes per select frame
   wire [2:0] sync_q; // Synchronised clock, select, data
   wire sck_s;
   wire ss_s;
   wire sdi_s;
   reg sck_d; // Clock level one cycle ago
   reg sel_d; // Effective select one cycle ago
   reg [2:0] bit_cnt; // Bits sampled in current byte
   reg [2:0] tx_cnt; // Index of bit on the output
   reg [7:0] tx_byte; // Byte being shifted out
   reg [7:0] rx_shift; // Byte being shifted in
   reg [7:0] last_rx; // Most recent complete byte, for echo
   reg [7:0] frame_bytes; // Bytes completed in this frame
   wire sel_raw;
   wire sel_eff;
   wire sck_lvl;
   wire lead;
   wire trail;
   wire sel_rise;
   wire sel_fall;
   wire sample_edge;
   wire shift_edge;
   wire load_now;
   wire [7:0] next_rx;
   wire byte_done;
   wire data_bit;
   wire fault_set;
   wire [`SCM_FLAG_W-1:0] flag_set;
   wire [`SCM_FLAG_W-1:0] flag_clr;
   // APB decode
   wire setup;
   wire access;
   wire wr_ctrl;
   wire wr_stat;
   wire wr_tcnt;
   wire tx_push;
   wire rx_pop;
   // Queues
   wire [7:0] tx_head;
   wire tx_empty;
   wire tx_full;
   wire tx_pop;
   wire [`SCM_FIFO_CW-1:0] tx_count;
   wire [7:0] rx_head;
   wire rx_empty;
   wire rx_full;
   wire rx_push;
   wire [`SCM_FIFO_CW-1:0] rx_count;
   wire [9:0] status;

   // ---------------------------------------------------------------
   // Pin synchronisation
   // ---------------------------------------------------------------
   scm_sync u_sync (
      .clk (pclk),
      .rst_n (presetn),
      .d ({sck_in, ss_in, sdi_in}),
      .q (sync_q)
   );

   assign sck_s = sync_q[2];
   assign ss_s = sync_q[1];
   assign sdi_s = sync_q[0];

   // ---------------------------------------------------------------
   // Select and clock edge detection
   // ---------------------------------------------------------------
   // Polarity chooses which pin level counts as selected
   assign sel_raw = ctrl[`SCM_C_SSPOL] ? ~ss_s : ss_s; // R13
   assign sel_eff = ctrl[`SCM_C_FORCE] | sel_raw; // R14
   // Normalise so that 0 is the idle level of the host clock
   assign sck_lvl = sck_s ^ ctrl[`SCM_C_CKPOL]; // R17
   // Clock edges only count while selected
   assign lead = sel_eff & sel_d & sck_lvl & ~sck_d; // R11
   assign trail = sel_eff & sel_d & ~sck_lvl & sck_d; // R11
   assign sel_rise = sel_eff & ~sel_d;
   assign sel_fall = ~sel_eff & sel_d;
   // Edge select picks which edge changes the output
   assign shift_edge = ctrl[`SCM_C_CKE] ? trail : lead; // R17
   assign sample_edge = ctrl[`SCM_C_CKE] ? lead : trail; // R17 R20

   // ---------------------------------------------------------------
   // Transmit byte selection
   // ---------------------------------------------------------------
   // A byte is loaded at select start when data leads the clock,
   // otherwise on the shift edge that follows the last bit
   assign load_now = (sel_rise & ctrl[`SCM_C_CKE]) |
                     (shift_edge & (tx_cnt == `SCM_BIT_LAST));
   // Only a required transmit consumes the queue entry
   assign tx_pop = load_now & ~tx_empty & ctrl[`SCM_C_TXREQ]; // R4 R5
   assign data_bit = ctrl[`SCM_C_LSBF] ? tx_byte[tx_cnt] :
                     tx_byte[`SCM_BIT_LAST - tx_cnt]; // R20

   // ---------------------------------------------------------------
   // Receive path
   // ---------------------------------------------------------------
   assign next_rx = ctrl[`SCM_C_LSBF] ? {sdi_s, rx_shift[7:1]} :
                    {rx_shift[6:0], sdi_s}; // R20
   assign byte_done = sample_edge & (bit_cnt == `SCM_BIT_LAST);
   assign rx_push = byte_done & ctrl[`SCM_C_RXREQ] & ~rx_full; // R8 R10

   // ---------------------------------------------------------------
   // Event flags; a set in the clearing cycle wins
   // ---------------------------------------------------------------
   // A frame is short if a byte is unfinished or fewer bytes came
   // than the transfer count asks for
   assign fault_set = sel_fall & ((bit_cnt != 3'd0) |
                      ((tcnt != 8'h00) & (frame_bytes < tcnt))); // R12
   assign flag_set[`SCM_S_UNDER] = load_now & tx_empty &
                                   ctrl[`SCM_C_TXREQ]; // R6 R7
   assign flag_set[`SCM_S_OVER] = byte_done & ctrl[`SCM_C_RXREQ] &
                                  rx_full; // R9
   assign flag_set[`SCM_S_FAULT] = fault_set;
   assign flag_set[`SCM_S_START] = sel_rise; // R19
   assign flag_set[`SCM_S_END] = sel_fall; // R19
   assign flag_clr = wr_stat ? pwdata[`SCM_FLAG_W-1:0] :
                     {`SCM_FLAG_W{1'b0}};

   // Flags clear by writing one
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= `SCM_FLAG_RESET;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   // ---------------------------------------------------------------
   // Serial engine
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_d <= 1'b0;
         sel_d <= 1'b0;
         bit_cnt <= 3'd0;
         tx_cnt <= `SCM_BIT_LAST;
         tx_byte <= 8'h00;
         rx_shift <= 8'h00;
         last_rx <= 8'h00;
         frame_bytes <= 8'h00;
      end else begin
         sck_d <= sck_lvl;
         sel_d <= sel_eff;
         if (sel_fall) begin
            // Back to idle; the next select starts a fresh byte
            bit_cnt <= 3'd0; // R15
            tx_cnt <= `SCM_BIT_LAST; // R15
            frame_bytes <= 8'h00; // R15
         end else begin
            // Output side: load a new byte or move to the next bit
            if (load_now) begin
               // Empty queue echoes the last byte received
               tx_byte <= tx_empty ? last_rx : tx_head; // R4 R5 R6 R7
               tx_cnt <= 3'd0;
            end else if (shift_edge) begin
               tx_cnt <= tx_cnt + 3'd1;
            end
            // Input side: one bit per sample edge
            if (sample_edge) begin
               rx_shift <= next_rx;
               bit_cnt <= bit_cnt + 3'd1;
            end
            if (byte_done) begin
               // Kept even when receive is not required
               last_rx <= next_rx; // R10
               if (frame_bytes != 8'hFF) begin
                  frame_bytes <= frame_bytes + 8'h01;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin drivers; enables are low while driving
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdo_out <= 1'b0;
         sdo_oe_n <= 1'b1;
         sck_out <= 1'b0;
         sck_oe_n <= 1'b1;
      end else begin
         if (!ctrl[`SCM_C_DIR]) begin
            // Always driven; latch level while not selected
            sdo_oe_n <= 1'b0; // R1
            sdo_out <= sel_eff ? data_bit : ctrl[`SCM_C_LAT]; // R2 R11
         end else if (ctrl[`SCM_C_TXREQ] & sel_eff) begin
            sdo_oe_n <= 1'b0; // R3
            sdo_out <= data_bit;
         end else begin
            sdo_oe_n <= 1'b1; // R3
            sdo_out <= 1'b0;
         end
         // Clock repeater for chained clients; delayed by the sync
         sck_out <= sck_s; // R18
         sck_oe_n <= ~ctrl[`SCM_C_SCKSEP]; // R18
      end
   end

   // ---------------------------------------------------------------
   // Queues
   // ---------------------------------------------------------------
   scm_fifo u_txq (
      .clk (pclk),
      .rst_n (presetn),
      .push (tx_push),
      .wdata (pwdata[7:0]),
      .pop (tx_pop),
      .head (tx_head),
      .empty (tx_empty),
      .full (tx_full),
      .count (tx_count)
   );

   scm_fifo u_rxq (
      .clk (pclk),
      .rst_n (presetn),
      .push (rx_push),
      .wdata (next_rx),
      .pop (rx_pop),
      .head (rx_head),
      .empty (rx_empty),
      .full (rx_full),
      .count (rx_count)
   );

   // ---------------------------------------------------------------
   // APB slave; zero wait states, read data captured in setup
   // ---------------------------------------------------------------
   assign pready = 1'b1;
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_ctrl = access & pwrite & (paddr == `SCM_OFF_CTRL);
   assign wr_stat = access & pwrite & (paddr == `SCM_OFF_STAT);
   assign wr_tcnt = access & pwrite & (paddr == `SCM_OFF_TCNT);
   // A write to a full transmit queue is dropped
   assign tx_push = access & pwrite & (paddr == `SCM_OFF_TXD);
   assign rx_pop = access & ~pwrite & (paddr == `SCM_OFF_RXD);
   assign status = {sel_eff, rx_full, tx_full, rx_empty, tx_empty,
                    flags};

   // Writable registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `SCM_CTRL_RESET;
         tcnt <= `SCM_TCNT_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= pwdata[`SCM_CTRL_W-1:0];
         end
         if (wr_tcnt) begin
            tcnt <= pwdata[7:0];
         end
      end
   end

   // Read data and error flag, held through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= 1'b0;
         case (paddr)
            `SCM_OFF_CTRL: prdata <= {22'h000000, ctrl};
            `SCM_OFF_STAT: prdata <= {22'h000000, status};
            `SCM_OFF_TXD: prdata <= {30'h00000000, tx_count};
            `SCM_OFF_RXD: prdata <= {24'h000000, rx_head};
            `SCM_OFF_TCNT: prdata <= {24'h000000, tcnt};
            default: begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end else if (!psel) begin
         pslverr <= 1'b0;
      end
   end

endmodule // scm_top

// file: logic/scm_consts.vh
// Offsets, field positions, reset values and sizes of the client block
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SCM_OFF_CTRL 8'h00
`define SCM_OFF_STAT 8'h04
`define SCM_OFF_TXD 8'h08
`define SCM_OFF_RXD 8'h0C
`define SCM_OFF_TCNT 8'h10

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SCM_CTRL_W 10
`define SCM_CTRL_RESET 10'h084
`define SCM_C_TXREQ 0
`define SCM_C_RXREQ 1
`define SCM_C_SSPOL 2
`define SCM_C_FORCE 3
`define SCM_C_CKPOL 4
`define SCM_C_CKE 5
`define SCM_C_LSBF 6
`define SCM_C_DIR 7
`define SCM_C_LAT 8
`define SCM_C_SCKSEP 9

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define SCM_FLAG_W 5
`define SCM_FLAG_RESET 5'h00
`define SCM_S_UNDER 0
`define SCM_S_OVER 1
`define SCM_S_FAULT 2
`define SCM_S_START 3
`define SCM_S_END 4
`define SCM_S_TXEMPTY 5
`define SCM_S_RXEMPTY 6
`define SCM_S_TXFULL 7
`define SCM_S_RXFULL 8
`define SCM_S_SEL 9

// ---------------------------------------------------------------
// Queue and transfer sizes
// ---------------------------------------------------------------
`define SCM_FIFO_DEPTH 2
`define SCM_FIFO_AW 1
`define SCM_FIFO_CW 2
`define SCM_BIT_LAST 3'd7
`define SCM_TCNT_RESET 8'h00

`endif

// file: logic/scm_sync.v
// Two-stage synchroniser for the serial pins
`timescale 1ns/100ps
module scm_sync (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Asynchronous inputs and their synchronised copies
   input wire [2:0] d,
   output reg [2:0] q
);

   reg [2:0] meta; // First stage, read only by the second stage

   // ---------------------------------------------------------------
   // Two flops per bit; the pins come from the host's clock domain
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Select bit starts at its idle high level: no false select
         meta <= 3'h2;
         q <= 3'h2;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // scm_sync

// file: logic/scm_fifo.v
// Small byte queue held in flip-flops
`timescale 1ns/100ps
`include "scm_consts.vh"
module scm_fifo (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Fill side
   input wire push,
   input wire [7:0] wdata,
   // Drain side
   input wire pop,
   output wire [7:0] head,
   // State
   output wire empty,
   output wire full,
   output wire [`SCM_FIFO_CW-1:0] count
);

   reg [7:0] mem [0:`SCM_FIFO_DEPTH-1]; // Byte storage
   reg [`SCM_FIFO_AW-1:0] rd_ptr; // Oldest entry
   reg [`SCM_FIFO_AW-1:0] wr_ptr; // Next free entry
   reg [`SCM_FIFO_CW-1:0] cnt; // Occupancy
   wire do_push;
   wire do_pop;

   // A push into a full queue is dropped here; the caller need not check full
   assign do_push = push & ~full;
   assign do_pop = pop & ~empty;
   assign empty = (cnt == {`SCM_FIFO_CW{1'b0}});
   assign full = (cnt == `SCM_FIFO_DEPTH);
   assign count = cnt;
   assign head = mem[rd_ptr];

   // ---------------------------------------------------------------
   // Pointers and occupancy
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ptr <= {`SCM_FIFO_AW{1'b0}};
         wr_ptr <= {`SCM_FIFO_AW{1'b0}};
         cnt <= {`SCM_FIFO_CW{1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_push & ~do_pop) begin
            cnt <= cnt + 1'b1;
         end else if (do_pop & ~do_push) begin
            cnt <= cnt - 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Storage; data only, so no reset is needed
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= wdata;
      end
   end

endmodule // scm_fifo

// file: tb/scm_chk.sv
// Port checker for the serial client block
`timescale 1ns/100ps
`include "scm_consts.vh"
module scm_chk (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Serial pins
   input wire sck_in,
   input wire ss_in,
   input wire sdi_in,
   input wire sdo_out,
   input wire sdo_oe_n,
   input wire sck_out,
   input wire sck_oe_n
);
// ------
// Shadow state
// ------
reg [9:0] ctrl; // Copy of the control register
reg [3:0] quiet; // Cycles since select or control moved
reg [3:0] sck_q; // Cycles since the clock pin moved
reg ss_d; // Sampled select pin
reg sck_d; // Sampled clock pin
wire ctrl_wr = psel && penable && pwrite && paddr == `SCM_OFF_CTRL;
// Synchronisers have long settled, so pin states are final
wire calm = quiet > 4'h9;
wire sel = ctrl[`SCM_C_FORCE] | (ctrl[`SCM_C_SSPOL] ? ~ss_d : ss_d);

// Snoop control writes; any change restarts the settle count
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      ctrl <= `SCM_CTRL_RESET;
      quiet <= 4'h0;
      sck_q <= 4'h0;
      ss_d <= 1'b1;
      sck_d <= 1'b0;
   end else begin
      if (ctrl_wr) begin
         ctrl <= pwdata[9:0];
      end
      ss_d <= ss_in;
      sck_d <= sck_in;
      quiet <= (ctrl_wr || ss_in != ss_d) ? 4'h0 :
         quiet + {3'h0, quiet != 4'hF};
      sck_q <= (sck_in != sck_d) ? 4'h0 : sck_q + {3'h0, sck_q != 4'hF};
   end
end

// ------
// Assertions
// ------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

a_zero_wait: assert property (psel && penable |-> pready)
   else $error("access phase without ready");
a_bad_err: assert property (psel && !penable && paddr > 8'h10 ##1 penable
   |-> pslverr) else $error("no error on unmapped access");
a_bad_data: assert property (psel && penable && paddr > 8'h10
   |-> prdata == 32'h0) else $error("data on unmapped access");
a_pin_driven: assert property (
   calm && !ctrl[`SCM_C_DIR] |-> !sdo_oe_n)
   else $error("data pin released with direction clear");
a_idle_latch: assert property (
   calm && !sel && !ctrl[`SCM_C_DIR] |-> sdo_out == ctrl[`SCM_C_LAT])
   else $error("idle data pin not at latch level");
a_tri_state: assert property (
   calm && ctrl[`SCM_C_DIR] && !(ctrl[`SCM_C_TXREQ] && sel) |-> sdo_oe_n)
   else $error("data pin driven while it should float");
a_drive_sel: assert property (
   calm && ctrl[`SCM_C_DIR] && ctrl[`SCM_C_TXREQ] && sel |-> !sdo_oe_n)
   else $error("data pin floats while selected");
a_clk_follow: assert property (
   calm && ctrl[`SCM_C_SCKSEP] && sck_q > 4'h2
   |-> sck_out == sck_d && !sck_oe_n)
   else $error("chained clock does not follow input");
a_clk_hidden: assert property (
   calm && !ctrl[`SCM_C_SCKSEP] |-> sck_oe_n)
   else $error("chained clock pin driven while unused");
endmodule // scm_chk

bind scm_top scm_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck_in),
   .ss_in(ss_in), .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
   .sck_out(sck_out), .sck_oe_n(sck_oe_n));

// file: tb/scm_host_model.sv
// Behavioural bus host that clocks the client
`timescale 1ns/100ps
module scm_host_model (
   // Settings that must match the client
   input wire idle_clk,
   input wire act_low,
   // Serial pins toward the client
   output reg sck,
   output reg ss,
   output reg sdi,
   input wire sdo,
   // Bits seen back, strobed once per frame
   output reg [15:0] rx_word,
   output reg rx_stb
);
reg busy; // High while a frame is on the wire
initial begin
   sdi = 1'b0;
   rx_word = 16'h0;
   rx_stb = 1'b0;
   busy = 1'b0;
end

// Clock stands still and select stays inactive between frames
always @* begin
   if (!busy) begin
      sck = idle_clk;
      ss = act_low;
   end
end

// One frame of nbits, first bit first; a short count makes a fault
task frame(input int nbits, input [15:0] tx);
   int i;
   begin
      busy = 1'b1;
      rx_word = 16'h0;
      // Pins move off the bus clock edge, never on it
      #10 ss = ~act_low;
      #400;
      for (i = 0; i < nbits; i++) begin
         sdi = tx[15 - i];
         sck = ~idle_clk;
         #160 sck = idle_clk;
         // Late sampling leaves room for the synchroniser delay
         #140 rx_word = {rx_word[14:0], sdo};
         #20;
      end
      #200 ss = act_low;
      sdi = ~sdi; // Released line shows no stale level
      #400 busy = 1'b0;
      rx_stb = 1'b1;
      #10 rx_stb = 1'b0;
   end
endtask
endmodule // scm_host_model

// file: tb/spi_client_mode_datapath_tb.sv
// Self-checking bench for the serial client block
`timescale 1ns/100ps
`include "scm_consts.vh"
module spi_client_mode_datapath_tb;
// ------
// Signals
// ------
logic pclk = 1'b0; // 25 MHz bus clock
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic idle_clk = 1'b0; // Host clock idle level
logic act_low = 1'b1; // Host select polarity
logic [31:0] rs = 32'h12A68; // Random state
logic [7:0] b [4]; // Bytes for the send queue
logic [15:0] t [4]; // Words sent by the host
logic [63:0] exp_rd [$]; // Mask and value per read
logic [63:0] exp_rx [$]; // Mask and value per frame
int fail_count = 0;
int checks_done = 0;
wire [31:0] prdata;
wire pready, pslverr, sdo_out, sdo_oe_n, sck_out, sck_oe_n;
wire sck, ss, sdi, rx_stb;
wire [15:0] rx_word;
wire sdo_line = sdo_oe_n ? 1'b1 : sdo_out; // Pulled up when released

always #20 pclk = ~pclk;

scm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_in(sck),
   .ss_in(ss), .sdi_in(sdi), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
   .sck_out(sck_out), .sck_oe_n(sck_oe_n));
scm_host_model i_host (.idle_clk(idle_clk), .act_low(act_low), .sck(sck),
   .ss(ss), .sdi(sdi), .sdo(sdo_line), .rx_word(rx_word), .rx_stb(rx_stb));

// ------
// Helpers
// ------
function logic [31:0] rnd();
   rs = rs ^ (rs << 13);
   rs = rs ^ (rs >> 17);
   rs = rs ^ (rs << 5);
   return rs;
endfunction

// Bit order as the host sees an lsb-first byte
function logic [7:0] rev(logic [7:0] v);
   for (int k = 0; k < 8; k++) rev[k] = v[7 - k];
endfunction

task cmp(string n, logic [63:0] e, logic [31:0] s);
   checks_done++;
   if ((s & e[63:32]) !== (e[31:0] & e[63:32])) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e[31:0], s);
   end
endtask

// One APB transfer; reads leave their expectation for the watcher
task apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_rd.push_back({m, d});
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for ready
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   end
endtask

// One host frame and what the host should see back
task frm(int n, logic [15:0] tx, logic [15:0] m, logic [15:0] e);
   exp_rx.push_back({16'h0, m, 16'h0, e});
   i_host.frame(n, tx);
endtask

task results;
   $display("checks %0d, mismatches %0d", checks_done, fail_count);
   if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
   else $display("Simulation failed");
   $finish;
endtask

// Watchers take the oldest note whenever a result appears
always @(posedge pclk) begin
   if (psel && penable && !pwrite && pready === 1'b1 && exp_rd.size())
      cmp("read data", exp_rd.pop_front(), prdata);
end
always @(posedge rx_stb) begin
   if (exp_rx.size()) cmp("host data", exp_rx.pop_front(), rx_word);
end

// Hang guard
initial begin
   #300000;
   fail_count++;
   results;
end

// ------
// Main sequence
// ------
initial begin
   for (int i = 0; i < 4; i++) begin
      rs = rnd();
      b[i] = rs[7:0];
      t[i] = rs[23:8];
   end
   repeat (2) @(posedge pclk);
   presetn <= 1'b1;
   apb(0, `SCM_OFF_CTRL, 32'h84, 32'h3FF);
   apb(0, `SCM_OFF_STAT, 32'h60, 32'h3FF);
   apb(0, 8'h20, 32'h0, 32'hFFFFFFFF);
   // Removing sends, then underflow echoes
   apb(1, `SCM_OFF_CTRL, 32'h87, 0);
   apb(1, `SCM_OFF_TXD, b[0], 0);
   frm(16, t[0], 16'hFFFF, {b[0], t[0][15:8]});
   apb(0, `SCM_OFF_STAT, 32'h139, 32'h3FF);
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   apb(0, `SCM_OFF_RXD, t[0][15:8], 32'hFF);
   apb(0, `SCM_OFF_RXD, t[0][7:0], 32'hFF);
   apb(0, `SCM_OFF_TXD, 32'h0, 32'hFF);
   // Non-removing sends keep the byte queued
   apb(1, `SCM_OFF_CTRL, 32'h6, 0);
   apb(1, `SCM_OFF_TXD, b[1], 0);
   frm(16, t[1], 16'hFFFF, {b[1], b[1]});
   apb(0, `SCM_OFF_TXD, 32'h1, 32'hFF);
   apb(0, `SCM_OFF_STAT, 32'h118, 32'h3FF);
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   // Receive queue full: byte dropped
   apb(1, `SCM_OFF_CTRL, 32'h7, 0);
   frm(8, t[2], 16'hFF, b[1]);
   apb(0, `SCM_OFF_STAT, 32'h13A, 32'h3FF);
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   apb(0, `SCM_OFF_RXD, t[1][15:8], 32'hFF);
   apb(0, `SCM_OFF_RXD, t[1][7:0], 32'hFF);
   // Empty send queue echoes, nothing stored
   apb(1, `SCM_OFF_CTRL, 32'h104, 0);
   frm(16, t[3], 16'hFFFF, {t[2][15:8], t[3][15:8]});
   apb(0, `SCM_OFF_STAT, 32'h78, 32'h3FF);
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   // Short frame faults, next one starts afresh
   apb(1, `SCM_OFF_CTRL, 32'h84, 0);
   frm(4, t[0], 16'hFFFF, 16'h000F);
   apb(0, `SCM_OFF_STAT, 32'h4, 32'h4);
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   apb(1, `SCM_OFF_CTRL, 32'hC5, 0);
   apb(1, `SCM_OFF_TXD, b[2], 0);
   frm(8, t[1], 16'hFF, rev(b[2]));
   apb(0, `SCM_OFF_STAT, 32'h0, 32'h7);
   // Active-high select, high idle clock, chained clock pin
   apb(1, `SCM_OFF_CTRL, 32'h213, 0);
   idle_clk <= 1'b1;
   act_low <= 1'b0;
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   apb(1, `SCM_OFF_TXD, b[3], 0);
   apb(1, `SCM_OFF_TCNT, 32'h2, 0);
   frm(8, t[2], 16'hFF, b[3]);
   apb(0, `SCM_OFF_STAT, 32'h4, 32'h4);
   // Forced select raises and drops the effective select
   apb(1, `SCM_OFF_STAT, 32'h1F, 0);
   apb(1, `SCM_OFF_CTRL, 32'h8, 0);
   repeat (4) @(posedge pclk);
   apb(0, `SCM_OFF_STAT, 32'h208, 32'h208);
   apb(1, `SCM_OFF_CTRL, 32'h0, 0);
   repeat (4) @(posedge pclk);
   apb(0, `SCM_OFF_STAT, 32'h10, 32'h210);
   repeat (4) @(posedge pclk);
   results;
end
endmodule // spi_client_mode_datapath_tb
